//--- verilog/pmbe_slave.sv
`timescale 1ns/1ps
module pmbe_slave import pmbe_pkg::*; #(
  parameter int TIMEOUT_CYC = PMBE_TIMEOUT_CYC
) (
  input logic mclk,
  input logic reset_n,
  pmbe_bus_if.slave bus,
  input logic [3:0] addr_sel,
  input logic [7:0] wr_len,
  input logic rx_ready,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic tx_req,
  input logic tx_valid,
  input logic [7:0] tx_data,
  input logic tx_last,
  output logic [7:0] cmd_code,
  output logic cmd_ext,
  output logic cmd_exec,
  output logic pec_err,
  output logic timeout,
  output logic [6:0] own_addr
);
  localparam int TW = $clog2(TIMEOUT_CYC + 1);
  localparam logic [TW-1:0] TMO_LAST = TW'(TIMEOUT_CYC - 1);

  typedef struct packed {
    logic [2:0] scl_sy;
    logic [2:0] sda_sy;
    logic scl_f;
    logic sda_f;
    logic [11:0] strap_sy;
    logic [1:0] strap_cnt;
    logic strap_done;
    logic [6:0] addr;
    pmbe_sst_t st;
    logic [7:0] sh;
    logic [3:0] bcnt;
    logic [1:0] hdr;
    logic [7:0] didx;
    logic [7:0] cmd;
    logic ext;
    logic [7:0] crc;
    logic rd;
    logic mine;
    logic bad;
    logic pec_ok;
    logic pending;
    logic wt;
    logic hold;
    logic sda_low;
    logic [7:0] tx;
    logic tx_pec;
    logic tx_done;
    logic mack;
    logic [7:0] rxd;
    logic rxv;
    logic exec;
    logic perr;
    logic tmo;
    logic [TW-1:0] tcnt;
  } pmbe_sl_t;

  pmbe_sl_t q_ff;
  pmbe_sl_t nxt_q;
  logic sta;
  logic sto;
  logic rise;
  logic fall;
  logic go;
  logic seg_ok;
  logic hit;
  logic [7:0] tbyte;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    nxt_q = q_ff;
    tbyte = PMBE_IDLE_BYTE;
    hit = 1'b0;
    // Three-stage synchronisers, a change counts once stages two and three agree
    nxt_q.scl_sy = {q_ff.scl_sy[1:0], bus.scl};
    nxt_q.sda_sy = {q_ff.sda_sy[1:0], bus.sda};
    nxt_q.strap_sy = {q_ff.strap_sy[7:0], addr_sel};
    if (q_ff.scl_sy[1] == q_ff.scl_sy[2]) begin
      nxt_q.scl_f = q_ff.scl_sy[2];
    end
    if (q_ff.sda_sy[1] == q_ff.sda_sy[2]) begin
      nxt_q.sda_f = q_ff.sda_sy[2];
    end
    rise = !q_ff.scl_f && nxt_q.scl_f;
    fall = q_ff.scl_f && !nxt_q.scl_f;
    // Data edge while clock stays high
    sta = q_ff.scl_f && nxt_q.scl_f && q_ff.sda_f && !nxt_q.sda_f;
    sto = q_ff.scl_f && nxt_q.scl_f && !q_ff.sda_f && nxt_q.sda_f;
    nxt_q.rxv = 1'b0;
    nxt_q.exec = 1'b0;
    nxt_q.perr = 1'b0;
    nxt_q.tmo = 1'b0;
    // Address strap caught after release of reset
    if (!q_ff.strap_done) begin
      if (q_ff.strap_cnt != PMBE_STRAP_WAIT) begin
        nxt_q.strap_cnt = q_ff.strap_cnt + 2'h1;
      end
      // Strap is taken only once stages two and three agree
      if (q_ff.strap_cnt == PMBE_STRAP_WAIT && q_ff.strap_sy[11:8] == q_ff.strap_sy[7:4]) begin
        nxt_q.addr = PMBE_BASE_ADDR | {3'h0, q_ff.strap_sy[11:8]};
        nxt_q.strap_done = 1'b1;
      end
    end
    // Own write segment complete, with or without error byte
    seg_ok = q_ff.mine && !q_ff.rd && (q_ff.hdr == 2'h2) && !q_ff.bad &&
             ((q_ff.didx == wr_len) || q_ff.pec_ok);
    // Stall until the user side can take or give a byte
    case (q_ff.st)
      SS_RX: go = (q_ff.hdr != 2'h2) || (q_ff.didx >= wr_len) || rx_ready;
      SS_TX: go = q_ff.tx_pec || q_ff.tx_done || tx_valid;
      default: go = 1'b1;
    endcase
    // Clock-low watchdog, cleared whenever the clock is high
    if (q_ff.st == SS_IDLE || nxt_q.scl_f) begin
      nxt_q.tcnt = '0;
    end else if (q_ff.tcnt != TMO_LAST) begin
      nxt_q.tcnt = q_ff.tcnt + TW'(1);
    end
    if (sto) begin
      nxt_q.exec = q_ff.pending || seg_ok;
      nxt_q.pending = 1'b0;
      nxt_q.st = SS_IDLE;
      nxt_q.hold = 1'b0;
      nxt_q.sda_low = 1'b0;
      nxt_q.wt = 1'b0;
      nxt_q.mine = 1'b0;
    end else if (sta) begin
      // A restart closes our segment but keeps it for the final stop
      nxt_q.pending = q_ff.pending || seg_ok;
      nxt_q.mine = 1'b0;
      nxt_q.st = SS_ADDR;
      nxt_q.bcnt = 4'h0;
      nxt_q.hold = 1'b0;
      nxt_q.sda_low = 1'b0;
      nxt_q.wt = 1'b0;
    end else if (q_ff.tcnt == TMO_LAST) begin
      nxt_q.tmo = 1'b1;
      nxt_q.st = SS_IDLE;
      nxt_q.hold = 1'b0;
      nxt_q.sda_low = 1'b0;
      nxt_q.wt = 1'b0;
      nxt_q.pending = 1'b0;
      nxt_q.mine = 1'b0;
      nxt_q.tcnt = '0;
    end else begin
      case (q_ff.st)
        SS_ADDR, SS_RX: begin
          if (rise && q_ff.bcnt < PMBE_BYTE_BITS) begin
            nxt_q.sh = {q_ff.sh[6:0], nxt_q.sda_f};
            nxt_q.bcnt = q_ff.bcnt + 4'h1;
          end
          // Byte done: grab the clock, which is already low
          if (fall && q_ff.bcnt == PMBE_BYTE_BITS) begin
            nxt_q.wt = 1'b1;
            nxt_q.hold = 1'b1;
          end
          if (q_ff.wt && go) begin
            nxt_q.wt = 1'b0;
            nxt_q.hold = 1'b0;
            if (q_ff.st == SS_ADDR) begin
              // Ten-bit headers never match either address
              hit = (q_ff.strap_done && q_ff.sh[7:1] == q_ff.addr) ||
                    (q_ff.sh[7:1] == PMBE_GC_ADDR && q_ff.sh[0] == PMBE_BIT_WR);
              nxt_q.mine = hit;
              nxt_q.rd = (q_ff.sh[0] == PMBE_BIT_RD);
              nxt_q.sda_low = hit;
              nxt_q.st = hit ? SS_AACK : SS_SKIP;
              if (hit && q_ff.sh[0] == PMBE_BIT_WR) begin
                // Each write segment starts a fresh code
                nxt_q.crc = pmbe_crc8(PMBE_CRC_INIT, q_ff.sh);
                nxt_q.hdr = 2'h0;
                nxt_q.didx = 8'h00;
                nxt_q.bad = 1'b0;
                nxt_q.pec_ok = 1'b0;
              end else if (hit) begin
                // Read turnaround continues the code of the write part
                nxt_q.crc = pmbe_crc8(q_ff.crc, q_ff.sh);
                nxt_q.pending = 1'b0;
                nxt_q.tx_pec = 1'b0;
                nxt_q.tx_done = 1'b0;
              end
            end else begin
              nxt_q.sda_low = 1'b1;
              nxt_q.st = SS_RACK;
              case (q_ff.hdr)
                2'h0: begin
                  nxt_q.cmd = q_ff.sh;
                  nxt_q.ext = 1'b0;
                  nxt_q.hdr = (q_ff.sh == PMBE_EXT_CODE) ? 2'h1 : 2'h2;
                  nxt_q.crc = pmbe_crc8(q_ff.crc, q_ff.sh);
                end
                2'h1: begin
                  nxt_q.cmd = q_ff.sh;
                  nxt_q.ext = 1'b1;
                  nxt_q.hdr = 2'h2;
                  nxt_q.crc = pmbe_crc8(q_ff.crc, q_ff.sh);
                end
                default: begin
                  if (q_ff.didx < wr_len) begin
                    nxt_q.rxd = q_ff.sh;
                    nxt_q.rxv = 1'b1;
                    nxt_q.crc = pmbe_crc8(q_ff.crc, q_ff.sh);
                  end else if (q_ff.didx == wr_len && q_ff.sh == q_ff.crc) begin
                    nxt_q.pec_ok = 1'b1;
                  end else begin
                    // Wrong error byte or surplus byte
                    nxt_q.bad = 1'b1;
                    nxt_q.perr = (q_ff.didx == wr_len);
                    nxt_q.sda_low = 1'b0;
                  end
                  if (q_ff.didx != 8'hff) begin
                    nxt_q.didx = q_ff.didx + 8'h01;
                  end
                end
              endcase
            end
          end
        end
        SS_AACK: begin
          if (fall) begin
            nxt_q.sda_low = 1'b0;
            nxt_q.bcnt = 4'h0;
            nxt_q.st = q_ff.rd ? SS_TX : SS_RX;
            nxt_q.wt = q_ff.rd;
            nxt_q.hold = q_ff.rd;
          end
        end
        SS_RACK: begin
          if (fall) begin
            nxt_q.sda_low = 1'b0;
            nxt_q.bcnt = 4'h0;
            nxt_q.st = SS_RX;
          end
        end
        SS_TX: begin
          if (q_ff.wt && go) begin
            nxt_q.wt = 1'b0;
            nxt_q.hold = 1'b0;
            if (q_ff.tx_done) begin
              tbyte = PMBE_IDLE_BYTE;
            end else if (q_ff.tx_pec) begin
              tbyte = q_ff.crc;
              nxt_q.tx_pec = 1'b0;
              nxt_q.tx_done = 1'b1;
            end else begin
              tbyte = tx_data;
              nxt_q.crc = pmbe_crc8(q_ff.crc, tx_data);
              nxt_q.tx_pec = tx_last;
            end
            nxt_q.tx = tbyte;
            nxt_q.sda_low = !tbyte[7];
            nxt_q.bcnt = 4'h1;
          end else if (fall && !q_ff.wt) begin
            if (q_ff.bcnt < PMBE_BYTE_BITS) begin
              nxt_q.tx = {q_ff.tx[6:0], 1'b0};
              nxt_q.sda_low = !q_ff.tx[6];
              nxt_q.bcnt = q_ff.bcnt + 4'h1;
            end else begin
              nxt_q.sda_low = 1'b0;
              nxt_q.st = SS_TACK;
            end
          end
        end
        SS_TACK: begin
          if (rise) begin
            nxt_q.mack = (nxt_q.sda_f == PMBE_BIT_ACK);
          end
          if (fall) begin
            nxt_q.st = q_ff.mack ? SS_TX : SS_SKIP;
            nxt_q.wt = q_ff.mack;
            nxt_q.hold = q_ff.mack;
          end
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      q_ff <= '{scl_sy: 3'h7, sda_sy: 3'h7, scl_f: 1'b1, sda_f: 1'b1, st: SS_IDLE,
                default: '0};
    end else begin
      q_ff <= nxt_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign bus.s_scl_lvl = 1'b0;
  assign bus.s_sda_lvl = 1'b0;
  assign bus.s_scl_oe_n = !q_ff.hold;
  assign bus.s_sda_oe_n = !q_ff.sda_low;
  assign tx_req = q_ff.wt && (q_ff.st == SS_TX) && !q_ff.tx_pec && !q_ff.tx_done;
  assign rx_data = q_ff.rxd;
  assign rx_valid = q_ff.rxv;
  assign cmd_code = q_ff.cmd;
  assign cmd_ext = q_ff.ext;
  assign cmd_exec = q_ff.exec;
  assign pec_err = q_ff.perr;
  assign timeout = q_ff.tmo;
  assign own_addr = q_ff.addr;
endmodule : pmbe_slave

//--- verilog/pmbe_pkg.sv
// Operation
// - Master opens with address write, then command
// - Every transfer also works without error byte
// - Code 0xfe prefixes a second command byte
// - Group segments split by restarts, executed at stop
// - Group error byte covers own segment only
// - Hold clock low while not ready
// - Stretch clock only during its low phase
// - Clock low 25 ms releases lines, idles engine
// - Data change with clock high is start/stop
// - Repeated start turns around reads and splits group segments
// - Acknowledge own address and general call
// - Strap selects address 0x40 to 0x4f
// - Work at 100 kHz and 400 kHz
// - Never acknowledge ten-bit addressing
// - Error code spans address, command, data bytes
// - Last data sender appends the error byte
// - Bad error byte is refused, command dropped
// - CRC-8 polynomial 0x07, bytewise in bus order
// - Write 0, read 1, ack 0, nack 1
// - Execute command only at the stop
// - Low byte first, each byte MSB first
package pmbe_pkg;
  localparam logic [6:0] PMBE_GC_ADDR = 7'h00;
  localparam logic [6:0] PMBE_BASE_ADDR = 7'h40;
  localparam logic [7:0] PMBE_EXT_CODE = 8'hfe;
  localparam logic [7:0] PMBE_CRC_POLY = 8'h07;
  localparam logic [7:0] PMBE_CRC_INIT = 8'h00;
  localparam logic [7:0] PMBE_IDLE_BYTE = 8'hff;
  localparam logic PMBE_BIT_WR = 1'b0;
  localparam logic PMBE_BIT_RD = 1'b1;
  localparam logic PMBE_BIT_ACK = 1'b0;
  localparam logic PMBE_BIT_NACK = 1'b1;
  localparam logic [3:0] PMBE_BYTE_BITS = 4'h8;
  localparam logic [1:0] PMBE_STRAP_WAIT = 2'h3;
  localparam int PMBE_CLK_MHZ = 200;
  localparam int PMBE_TIMEOUT_MS = 25;
  localparam int PMBE_TIMEOUT_CYC = PMBE_TIMEOUT_MS * 1000 * PMBE_CLK_MHZ;
  localparam int PMBE_STD_KHZ = 100;
  localparam int PMBE_FAST_KHZ = 400;
  localparam int PMBE_HALF_STD = PMBE_CLK_MHZ * 1000 / (2 * PMBE_STD_KHZ);
  localparam int PMBE_HALF_FAST = PMBE_CLK_MHZ * 1000 / (2 * PMBE_FAST_KHZ);

  // Slave protocol states
  typedef enum logic [2:0] {
    SS_IDLE = 3'h0, SS_ADDR = 3'h1, SS_AACK = 3'h2, SS_RX = 3'h3,
    SS_RACK = 3'h4, SS_TX = 3'h5, SS_TACK = 3'h6, SS_SKIP = 3'h7
  } pmbe_sst_t;

  // Master bus phases
  typedef enum logic [3:0] {
    MS_IDLE = 4'h0, MS_STA_A = 4'h1, MS_STA_R = 4'h2, MS_STA_H = 4'h3,
    MS_STA_B = 4'h4, MS_BIT_L = 4'h5, MS_BIT_R = 4'h6, MS_BIT_H = 4'h7,
    MS_STO_A = 4'h8, MS_STO_R = 4'h9, MS_STO_H = 4'ha, MS_STO_E = 4'hb
  } pmbe_mst_t;

  // Master byte-level operations
  typedef enum logic [2:0] {
    PMBE_OP_START = 3'h0, PMBE_OP_WRITE = 3'h1, PMBE_OP_READ = 3'h2,
    PMBE_OP_STOP = 3'h3, PMBE_OP_PEC = 3'h4
  } pmbe_op_t;

  // One byte step of the packet error code, MSB first
  function automatic logic [7:0] pmbe_crc8(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    c = crc ^ data;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ({c[6:0], 1'b0} ^ PMBE_CRC_POLY) : {c[6:0], 1'b0};
    end
    return c;
  endfunction : pmbe_crc8
endpackage : pmbe_pkg

//--- verilog/pmbe_bus_if.sv
`timescale 1ns/1ps
// Open-drain two-wire bus joining master and slave ends
interface pmbe_bus_if;
  logic m_scl_lvl;
  logic m_scl_oe_n;
  logic m_sda_lvl;
  logic m_sda_oe_n;
  logic s_scl_lvl;
  logic s_scl_oe_n;
  logic s_sda_lvl;
  logic s_sda_oe_n;
  logic scl;
  logic sda;

  // Wired-and line levels with pull-up
  assign scl = !((!m_scl_oe_n && !m_scl_lvl) || (!s_scl_oe_n && !s_scl_lvl));
  assign sda = !((!m_sda_oe_n && !m_sda_lvl) || (!s_sda_oe_n && !s_sda_lvl));

  modport master (input scl, input sda, output m_scl_lvl, output m_scl_oe_n,
                  output m_sda_lvl, output m_sda_oe_n);
  modport slave (input scl, input sda, output s_scl_lvl, output s_scl_oe_n,
                 output s_sda_lvl, output s_sda_oe_n);
endinterface : pmbe_bus_if

//--- verilog/pmbe_master.sv
`timescale 1ns/1ps
module pmbe_master import pmbe_pkg::*; #(
  parameter int HALF_CYC = PMBE_HALF_STD
) (
  input logic mclk,
  input logic reset_n,
  pmbe_bus_if.master bus,
  input logic cmd_valid,
  output logic cmd_ready,
  input logic [2:0] cmd_op,
  input logic [7:0] cmd_data,
  input logic cmd_nack,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_ack,
  output logic rsp_crc_ok
);
  localparam int CW = $clog2(HALF_CYC + 1);
  localparam logic [CW-1:0] HALF_LAST = CW'(HALF_CYC - 1);

  typedef struct packed {
    logic [2:0] scl_sy;
    logic [2:0] sda_sy;
    logic scl_f;
    logic sda_f;
    pmbe_mst_t st;
    logic [CW-1:0] cnt;
    logic rd;
    logic nack;
    logic [7:0] sh;
    logic [3:0] bcnt;
    logic scl_low;
    logic sda_low;
    logic [7:0] crc;
    logic rv;
    logic [7:0] rdata;
    logic rack;
    logic rok;
  } pmbe_ms_t;

  pmbe_ms_t q_ff;
  pmbe_ms_t nxt_q;
  logic half;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    nxt_q = q_ff;
    nxt_q.scl_sy = {q_ff.scl_sy[1:0], bus.scl};
    nxt_q.sda_sy = {q_ff.sda_sy[1:0], bus.sda};
    if (q_ff.scl_sy[1] == q_ff.scl_sy[2]) begin
      nxt_q.scl_f = q_ff.scl_sy[2];
    end
    if (q_ff.sda_sy[1] == q_ff.sda_sy[2]) begin
      nxt_q.sda_f = q_ff.sda_sy[2];
    end
    nxt_q.rv = 1'b0;
    half = (q_ff.cnt == HALF_LAST);
    nxt_q.cnt = half ? '0 : q_ff.cnt + CW'(1);
    case (q_ff.st)
      MS_IDLE: begin
        nxt_q.cnt = '0;
        if (cmd_valid) begin
          nxt_q.bcnt = 4'h0;
          nxt_q.rd = (cmd_op == PMBE_OP_READ);
          nxt_q.nack = cmd_nack;
          case (cmd_op)
            PMBE_OP_START: begin
              // Bit 0 keeps the code across a read turnaround
              if (!cmd_data[0]) begin
                nxt_q.crc = PMBE_CRC_INIT;
              end
              nxt_q.st = MS_STA_A;
            end
            PMBE_OP_WRITE: begin
              nxt_q.sh = cmd_data;
              nxt_q.crc = pmbe_crc8(q_ff.crc, cmd_data);
              nxt_q.st = MS_BIT_L;
            end
            PMBE_OP_PEC: begin
              nxt_q.sh = q_ff.crc;
              nxt_q.st = MS_BIT_L;
            end
            PMBE_OP_READ: nxt_q.st = MS_BIT_L;
            default: nxt_q.st = MS_STO_A;
          endcase
        end
      end
      // Start or repeated start: release, rise, then drop data
      MS_STA_A: begin
        nxt_q.sda_low = 1'b0;
        if (half) begin
          nxt_q.scl_low = 1'b0;
          nxt_q.st = MS_STA_R;
        end
      end
      MS_STA_R, MS_BIT_R, MS_STO_R: begin
        nxt_q.cnt = '0;
        if (q_ff.scl_f) begin
          nxt_q.st = (q_ff.st == MS_STA_R) ? MS_STA_H :
                     (q_ff.st == MS_BIT_R) ? MS_BIT_H : MS_STO_H;
        end
      end
      MS_STA_H: begin
        if (half) begin
          nxt_q.sda_low = 1'b1;
          nxt_q.st = MS_STA_B;
        end
      end
      MS_STA_B: begin
        if (half) begin
          nxt_q.scl_low = 1'b1;
          nxt_q.rv = 1'b1;
          nxt_q.rack = 1'b1;
          nxt_q.st = MS_IDLE;
        end
      end
      // Data set while clock is low
      MS_BIT_L: begin
        if (q_ff.bcnt == PMBE_BYTE_BITS) begin
          nxt_q.sda_low = q_ff.rd && (q_ff.nack == PMBE_BIT_ACK);
        end else begin
          nxt_q.sda_low = !q_ff.rd && !q_ff.sh[7];
        end
        if (half) begin
          nxt_q.scl_low = 1'b0;
          nxt_q.st = MS_BIT_R;
        end
      end
      MS_BIT_H: begin
        if (half) begin
          nxt_q.scl_low = 1'b1;
          if (q_ff.bcnt == PMBE_BYTE_BITS) begin
            nxt_q.rv = 1'b1;
            nxt_q.rdata = q_ff.sh;
            nxt_q.rack = q_ff.rd || (q_ff.sda_f == PMBE_BIT_ACK);
            if (q_ff.rd) begin
              nxt_q.crc = pmbe_crc8(q_ff.crc, q_ff.sh);
              nxt_q.rok = (pmbe_crc8(q_ff.crc, q_ff.sh) == 8'h00);
            end
            nxt_q.st = MS_IDLE;
          end else begin
            nxt_q.sh = {q_ff.sh[6:0], q_ff.sda_f};
            nxt_q.bcnt = q_ff.bcnt + 4'h1;
            nxt_q.st = MS_BIT_L;
          end
        end
      end
      // Stop: data low, clock up, data up
      MS_STO_A: begin
        nxt_q.sda_low = 1'b1;
        if (half) begin
          nxt_q.scl_low = 1'b0;
          nxt_q.st = MS_STO_R;
        end
      end
      MS_STO_H: begin
        if (half) begin
          nxt_q.sda_low = 1'b0;
          nxt_q.st = MS_STO_E;
        end
      end
      MS_STO_E: begin
        if (half) begin
          nxt_q.rv = 1'b1;
          nxt_q.rack = 1'b1;
          nxt_q.st = MS_IDLE;
        end
      end
      default: nxt_q.st = MS_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      q_ff <= '{scl_sy: 3'h7, sda_sy: 3'h7, scl_f: 1'b1, sda_f: 1'b1, st: MS_IDLE,
                default: '0};
    end else begin
      q_ff <= nxt_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign cmd_ready = (q_ff.st == MS_IDLE);
  assign bus.m_scl_lvl = 1'b0;
  assign bus.m_sda_lvl = 1'b0;
  assign bus.m_scl_oe_n = !q_ff.scl_low;
  assign bus.m_sda_oe_n = !q_ff.sda_low;
  assign rsp_valid = q_ff.rv;
  assign rsp_data = q_ff.rdata;
  assign rsp_ack = q_ff.rack;
  assign rsp_crc_ok = q_ff.rok;
endmodule : pmbe_master

//--- tb/pmbe_monitor.sv
`timescale 1ns/1ps
// Bus-side checks on the interface joining both ends
module pmbe_monitor #(
  parameter int TIMEOUT_CYC = 2000
) (
  input logic mclk,
  input logic reset_n,
  input logic scl,
  input logic sda,
  input logic s_scl_oe_n,
  input logic s_sda_oe_n,
  input logic s_scl_lvl,
  input logic s_sda_lvl
);
  int low_ff;

  // Cycles the clock line has stayed low
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      low_ff <= 0;
    end else begin
      low_ff <= scl ? 0 : low_ff + 1;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);

  ////////////////////////////////////////////////////////////////////////////////
  a_stretch_in_low: assert property ($fell(s_scl_oe_n) |-> !$past(scl))
    else $error("slave pulled clock in its high phase");
  a_scl_pull_zero: assert property (!s_scl_oe_n |-> !s_scl_lvl)
    else $error("slave drives clock to one");
  a_ack_drive_zero: assert property (!s_sda_oe_n |-> !s_sda_lvl)
    else $error("slave drives data to one");
  a_sda_moves_low: assert property ($changed(s_sda_oe_n) |-> !$past(scl))
    else $error("slave data changed with clock high");
  a_cond_bus_free: assert property (scl && $past(scl) && $changed(sda) |-> s_sda_oe_n)
    else $error("start or stop seen while slave drives data");
  a_timeout_release: assert property (low_ff > TIMEOUT_CYC + 8 |-> s_scl_oe_n && s_sda_oe_n)
    else $error("lines still held after clock low timeout");
  a_low_phase_min: assert property ($fell(scl) |-> !scl [*8])
    else $error("clock low phase too short");
  a_high_phase_min: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high phase too short");

  // Main scenarios reached
  c_stretch: cover property (!s_scl_oe_n [*8]);
  c_ack: cover property ($fell(s_sda_oe_n));
  c_timeout: cover property (low_ff == TIMEOUT_CYC);
endmodule : pmbe_monitor

//--- tb/tb_top.sv
`timescale 1ns/1ps
module tb_top import pmbe_pkg::*;;
  localparam int TO = 2000;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] addr_sel = 4'h0;
  logic [7:0] wr_len = 8'h00;
  logic rx_ready = 1'b1;
  logic tx_valid = 1'b0;
  logic cmd_valid = 1'b0;
  logic [2:0] cmd_op = 3'h0;
  logic [7:0] cmd_data = 8'h00;
  logic cmd_nack = 1'b0;
  logic [7:0] txb[2] = '{8'h00, 8'h00};
  logic [7:0] rx_data, tx_data, cmd_code, rsp_data;
  logic rx_valid, tx_req, tx_last, cmd_ext, cmd_exec, pec_err, timeout;
  logic cmd_ready, rsp_valid, rsp_ack, rsp_crc_ok;
  logic [6:0] own_addr, me;
  logic [7:0] rxq[$];
  int n_errors = 0, check_count = 0, n_exec = 0, n_perr = 0, n_to = 0, ti = 0;
  bit hold = 0;

  pmbe_bus_if u_bus ();
  pmbe_slave #(.TIMEOUT_CYC(TO)) u_pmbe_slave (.mclk(mclk), .reset_n(reset_n), .bus(u_bus),
    .addr_sel(addr_sel), .wr_len(wr_len), .rx_ready(rx_ready), .rx_data(rx_data),
    .rx_valid(rx_valid), .tx_req(tx_req), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_last(tx_last), .cmd_code(cmd_code), .cmd_ext(cmd_ext), .cmd_exec(cmd_exec),
    .pec_err(pec_err), .timeout(timeout), .own_addr(own_addr));
  pmbe_master #(.HALF_CYC(20)) u_pmbe_master (.mclk(mclk), .reset_n(reset_n), .bus(u_bus),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_data(cmd_data),
    .cmd_nack(cmd_nack), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ack(rsp_ack),
    .rsp_crc_ok(rsp_crc_ok));
  pmbe_monitor #(.TIMEOUT_CYC(TO)) u_mon (.mclk(mclk), .reset_n(reset_n), .scl(u_bus.scl),
    .sda(u_bus.sda), .s_scl_oe_n(u_bus.s_scl_oe_n), .s_sda_oe_n(u_bus.s_sda_oe_n),
    .s_scl_lvl(u_bus.s_scl_lvl), .s_sda_lvl(u_bus.s_sda_lvl));

  // Read data offered to the slave
  assign tx_data = txb[ti[0]];
  assign tx_last = (ti == 1);

  always #2.5 mclk = ~mclk;

  // User side of the slave: random readiness, read data, pulse counts
  always @(posedge mclk) begin
    rx_ready <= !hold && ($urandom % 3 != 0);
    if (rx_valid === 1'b1) rxq.push_back(rx_data);
    if (cmd_exec === 1'b1) n_exec++;
    if (pec_err === 1'b1) n_perr++;
    if (timeout === 1'b1) n_to++;
    if (tx_req === 1'b1 && tx_valid) begin
      tx_valid <= 1'b0;
      ti <= ti + 1;
    end else if (tx_req === 1'b1) begin
      tx_valid <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bytewise error code, polynomial 0x07
  function automatic logic [7:0] f_crc(input logic [7:0] c, input logic [7:0] d);
    c = c ^ d;
    for (int i = 0; i < 8; i++) c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
    return c;
  endfunction : f_crc

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic conclude;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude

  // Bounded wait for command accept (r=1) or response (r=0)
  task automatic wt(input bit r);
    int i = 0;
    do @(posedge mclk); while ((r ? cmd_ready : rsp_valid) !== 1'b1 && ++i < 9000);
    if (i >= 9000) begin
      n_errors++;
      conclude();
    end
  endtask : wt

  task automatic op(input pmbe_op_t o, input logic [7:0] d, input logic nk = 1'b0);
    @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd_op <= o;
    cmd_data <= d;
    cmd_nack <= nk;
    wt(1);
    cmd_valid <= 1'b0;
    wt(0);
  endtask : op

  // One write segment: start, address, bytes, optional good or bad error byte
  task automatic seg(input logic [6:0] a, input logic [7:0] b[$], input int pm, input logic ak);
    logic [7:0] c;
    c = f_crc(8'h00, {a, 1'b0});
    op(PMBE_OP_START, 8'h00);
    op(PMBE_OP_WRITE, {a, 1'b0});
    chk("addr ack", rsp_ack, ak);
    foreach (b[i]) begin
      op(PMBE_OP_WRITE, b[i]);
      chk("byte ack", rsp_ack, ak);
      c = f_crc(c, b[i]);
    end
    if (pm == 1) op(PMBE_OP_PEC, 8'h00);
    if (pm == 2) op(PMBE_OP_WRITE, c ^ 8'h01);
    if (pm != 0) chk("pec ack", rsp_ack, ak && pm == 1);
  endtask : seg

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] b[$];
    logic [7:0] c;
    logic [6:0] tbl[4];
    int n, pm, hd;
    logic ak;
    void'($urandom(71));
    for (int r = 0; r < 2; r++) begin
      @(posedge mclk);
      reset_n <= 1'b0;
      addr_sel <= (r == 0) ? 4'hf : 4'($urandom);
      repeat (8) @(posedge mclk);
      reset_n <= 1'b1;
      repeat (12) @(posedge mclk);
      me = 7'h40 | {3'h0, addr_sel};
      chk("own addr", own_addr, me);
      tbl = '{7'h00, 7'h50, 7'h78, me};
      for (int k = 0; k < 8; k++) begin
        n = $urandom % 3;
        pm = (k + r) % 3;
        hd = (k % 5 == 4) ? 2 : 1;
        ak = (k % 4 == 0 || k % 4 == 3);
        b.delete();
        if (hd == 2) b.push_back(8'hfe);
        b.push_back(8'($urandom % 254));
        repeat (n) b.push_back(8'($urandom));
        wr_len <= 8'(n);
        rxq.delete();
        n_exec = 0;
        n_perr = 0;
        seg(tbl[k % 4], b, pm, ak);
        chk("exec early", n_exec, 0);
        op(PMBE_OP_STOP, 8'h00);
        repeat (20) @(posedge mclk);
        chk("exec", n_exec, ak && pm != 2);
        chk("pec err", n_perr, ak && pm == 2);
        chk("rx count", rxq.size(), ak ? n : 0);
        foreach (rxq[i]) chk("rx byte", rxq[i], b[hd + i]);
        if (ak) chk("code", {cmd_ext, cmd_code}, {hd == 2, b[hd - 1]});
      end
    end
    // Read turnaround with trailing error byte from the slave
    txb[0] = 8'($urandom);
    txb[1] = 8'($urandom);
    ti = 0;
    wr_len <= 8'h00;
    b = '{8'h8b};
    seg(me, b, 0, 1'b1);
    op(PMBE_OP_START, 8'h01);
    op(PMBE_OP_WRITE, {me, 1'b1});
    chk("read addr ack", rsp_ack, 1'b1);
    c = f_crc(f_crc(f_crc(8'h00, {me, 1'b0}), 8'h8b), {me, 1'b1});
    for (int i = 0; i < 3; i++) begin
      op(PMBE_OP_READ, 8'h00, i == 2);
      chk("read byte", rsp_data, (i < 2) ? txb[i] : c);
      if (i < 2) c = f_crc(c, txb[i]);
    end
    chk("read crc ok", rsp_crc_ok, 1'b1);
    op(PMBE_OP_STOP, 8'h00);
    // Group: foreign segment, then own segment, one stop
    n_exec = 0;
    wr_len <= 8'h01;
    b = '{8'h21, 8'h5a};
    seg(7'h50, b, 1, 1'b0);
    b = '{8'h22, 8'($urandom)};
    seg(me, b, 1, 1'b1);
    op(PMBE_OP_STOP, 8'h00);
    repeat (20) @(posedge mclk);
    chk("group exec", n_exec, 1);
    chk("group code", cmd_code, 8'h22);
    // Clock held low by a stalled receiver until the timeout
    n_exec = 0;
    n_to = 0;
    hold = 1;
    op(PMBE_OP_START, 8'h00);
    op(PMBE_OP_WRITE, {me, 1'b0});
    op(PMBE_OP_WRITE, 8'h22);
    op(PMBE_OP_WRITE, 8'h33);
    hold = 0;
    op(PMBE_OP_STOP, 8'h00);
    repeat (20) @(posedge mclk);
    chk("timeout", n_to, 1);
    chk("timeout exec", n_exec, 0);
    conclude();
  end
endmodule : tb_top
